// file: verilog/srpc_regs.sv
// Reset and PLL control register bank behind the serial configuration port.
// Assumes the port pins are asynchronous to clk_i and much slower than it.
//
// Contract
// - Synth field 0x9 holds the PLL reset.
// - Lock field 0x9 holds lock detector reset.
// - Clock generator field 0x9 holds its reset.
// - Mux field 0x9 holds column multiplexer reset.
// - Front-end field 0x9 holds analogue front end.
// - Serializer field 0x9 holds serializer reset.
// - Power bit low powers the PLL down.
// - Enable bit low disables the PLL.
// - Bypass bit high bypasses; resets to one.
`timescale 1ns/10ps
module srpc_regs #(
  parameter logic [15:0] ID_VALUE = 16'h0a5c  // Arbitrary value.
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              ss_n_i,
  input  wire logic              sck_i,
  input  wire logic              mosi_i,
  output logic                   miso_o,
  output logic                   miso_oe_o,
  output logic [1:0]             variant_o,
  output srpc_pkg::srpc_rst_t    sub_rst_o,
  output srpc_pkg::srpc_pll_t    pll_ctrl_o
);
  import srpc_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_CMD, ST_DATA, ST_DONE} srpc_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and glitch filter; bit 2 select, 1 clock, 0 data.

  logic [2:0] s1_reg, s2_reg, s3_reg, filt_reg;
  logic [2:0] s1_next, s2_next, s3_next, filt_next;
  logic       sel_c, rise_c, fall_c, sdi_c;

  always_comb begin
    s1_next   = {ss_n_i, sck_i, mosi_i};
    s2_next   = s1_reg;
    s3_next   = s2_reg;
    filt_next = (~(s2_reg ^ s3_reg) & s3_reg) | ((s2_reg ^ s3_reg) & filt_reg);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_reg   <= 3'h4;
      s2_reg   <= 3'h4;
      s3_reg   <= 3'h4;
      filt_reg <= 3'h4;
    end else begin
      s1_reg   <= s1_next;
      s2_reg   <= s2_next;
      s3_reg   <= s3_next;
      filt_reg <= filt_next;
    end
  end

  always_comb begin
    sel_c  = ~filt_reg[2];
    rise_c = ~filt_reg[1] & filt_next[1];
    fall_c = filt_reg[1] & ~filt_next[1];
    sdi_c  = filt_next[0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial frame engine and register file.

  srpc_state_t       state_reg, state_next;
  logic [CNT_W-1:0]  cnt_reg, cnt_next;
  logic [DATA_W-1:0] sin_reg, sin_next;
  logic [DATA_W-1:0] sout_reg, sout_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic              wr_reg, wr_next;
  logic              oe_reg, oe_next;
  logic [1:0]        variant_reg, variant_next;
  logic [7:0]        synth_reg, synth_next;
  logic [3:0]        cgen_reg, cgen_next;
  logic [11:0]       analog_reg, analog_next;
  logic [2:0]        pwr_reg, pwr_next;
  srpc_rst_t         rst_reg, rst_next;
  srpc_pll_t         pll_reg, pll_next;
  logic              commit_c, load_c;
  logic [DATA_W-1:0] wdata_c;

  function automatic logic [DATA_W-1:0] read_mux(input logic [ADDR_W-1:0] a);
    logic [DATA_W-1:0] d;
    d = 16'h0000;
    case (a)
      OFS_ID:      d = ID_VALUE;
      OFS_VARIANT: d = {14'h0000, variant_reg};
      OFS_SYNTH:   d = {8'h00, synth_reg};
      OFS_CGEN:    d = {12'h000, cgen_reg};
      OFS_ANALOG:  d = {4'h0, analog_reg};
      OFS_PWR:     d = {13'h0000, pwr_reg};
      default:     d = 16'h0000;
    endcase
    return d;
  endfunction

  always_comb begin
    state_next   = state_reg;
    cnt_next     = cnt_reg;
    sin_next     = sin_reg;
    sout_next    = sout_reg;
    addr_next    = addr_reg;
    wr_next      = wr_reg;
    oe_next      = sel_c;
    variant_next = variant_reg;
    synth_next   = synth_reg;
    cgen_next    = cgen_reg;
    analog_next  = analog_reg;
    pwr_next     = pwr_reg;
    commit_c     = 1'b0;
    load_c       = 1'b0;
    wdata_c      = {sin_reg[DATA_W-2:0], sdi_c};
    case (state_reg)
      ST_IDLE: begin
        cnt_next = '0;
        if (sel_c) begin
          state_next = ST_CMD;
        end
      end
      ST_CMD: begin
        if (rise_c) begin
          sin_next = {sin_reg[DATA_W-2:0], sdi_c};
          cnt_next = cnt_reg + 5'd1;
          if (cnt_reg == CNT_W'(ADDR_W)) begin
            addr_next  = sin_reg[ADDR_W-1:0];
            wr_next    = sdi_c;
            load_c     = 1'b1;
            sout_next  = read_mux(sin_reg[ADDR_W-1:0]);
            state_next = ST_DATA;
          end
        end
      end
      ST_DATA: begin
        if (rise_c) begin
          sin_next = {sin_reg[DATA_W-2:0], sdi_c};
          cnt_next = cnt_reg + 5'd1;
          if (cnt_reg == CNT_W'(FRAME_BITS - 1)) begin
            commit_c   = wr_reg;
            state_next = ST_DONE;
          end
        end else if (fall_c && cnt_reg >= CNT_W'(ADDR_W + 2)) begin
          sout_next = {sout_reg[DATA_W-2:0], 1'b0};
        end
      end
      ST_DONE: begin
        cnt_next = cnt_reg;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    if (!sel_c) begin
      state_next = ST_IDLE;
    end
    if (commit_c) begin
      case (addr_reg)
        OFS_VARIANT: variant_next = wdata_c[1:0];
        OFS_SYNTH:   synth_next   = wdata_c[7:0];
        OFS_CGEN:    cgen_next    = wdata_c[3:0];
        OFS_ANALOG:  analog_next  = wdata_c[11:0];
        OFS_PWR:     pwr_next     = wdata_c[2:0];
        default:     variant_next = variant_reg;
      endcase
    end
  end

  always_comb begin
    rst_next.pll        = synth_reg[SYN_PLL_LSB+:4] == HOLD_CODE;
    rst_next.lock_det   = synth_reg[SYN_LOCK_LSB+:4] == HOLD_CODE;
    rst_next.clk_gen    = cgen_reg[CGEN_LSB+:4] == HOLD_CODE;
    rst_next.col_mux    = analog_reg[ANA_MUX_LSB+:4] == HOLD_CODE;
    rst_next.afe        = analog_reg[ANA_AFE_LSB+:4] == HOLD_CODE;
    rst_next.serializer = analog_reg[ANA_SER_LSB+:4] == HOLD_CODE;
    pll_next.power_on   = pwr_reg[PWR_ON_BIT];
    pll_next.enable     = pwr_reg[PWR_EN_BIT];
    pll_next.bypass     = pwr_reg[PWR_BYP_BIT];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg   <= ST_IDLE;
      cnt_reg     <= '0;
      sin_reg     <= '0;
      sout_reg    <= '0;
      addr_reg    <= '0;
      wr_reg      <= 1'b0;
      oe_reg      <= 1'b0;
      variant_reg <= VARIANT_RST;
      synth_reg   <= SYNTH_RST;
      cgen_reg    <= CGEN_RST;
      analog_reg  <= ANALOG_RST;
      pwr_reg     <= PWR_RST;
      rst_reg     <= '1;
      pll_reg.power_on <= PWR_RST[PWR_ON_BIT];
      pll_reg.enable   <= PWR_RST[PWR_EN_BIT];
      pll_reg.bypass   <= PWR_RST[PWR_BYP_BIT];
    end else begin
      state_reg   <= state_next;
      cnt_reg     <= cnt_next;
      sin_reg     <= sin_next;
      sout_reg    <= sout_next;
      addr_reg    <= addr_next;
      wr_reg      <= wr_next;
      oe_reg      <= oe_next;
      variant_reg <= variant_next;
      synth_reg   <= synth_next;
      cgen_reg    <= cgen_next;
      analog_reg  <= analog_next;
      pwr_reg     <= pwr_next;
      rst_reg     <= rst_next;
      pll_reg     <= pll_next;
    end
  end

  assign miso_o     = sout_reg[DATA_W-1];
  assign miso_oe_o  = oe_reg;
  assign variant_o  = variant_reg;
  assign sub_rst_o  = rst_reg;
  assign pll_ctrl_o = pll_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  pll_hold_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (commit_c && addr_reg == OFS_SYNTH && wdata_c[3:0] == HOLD_CODE)
      |-> ##2 rst_reg.pll)
    else $error("PLL not held after hold code.");

  lock_release_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (commit_c && addr_reg == OFS_SYNTH && wdata_c[7:4] != HOLD_CODE)
      |-> ##2 !rst_reg.lock_det)
    else $error("Lock detector not released.");

  cgen_hold_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (commit_c && addr_reg == OFS_CGEN && wdata_c[3:0] == HOLD_CODE)
      |-> ##2 rst_reg.clk_gen)
    else $error("Clock generator not held.");

  mux_release_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (commit_c && addr_reg == OFS_ANALOG && wdata_c[3:0] != HOLD_CODE)
      |-> ##2 !rst_reg.col_mux)
    else $error("Column mux not released.");

  afe_hold_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (commit_c && addr_reg == OFS_ANALOG && wdata_c[7:4] == HOLD_CODE)
      |-> ##2 rst_reg.afe)
    else $error("Front end not held.");

  ser_hold_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (commit_c && addr_reg == OFS_ANALOG && wdata_c[11:8] == HOLD_CODE)
      |-> ##2 rst_reg.serializer)
    else $error("Serializer not held.");

  pll_power_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (commit_c && addr_reg == OFS_PWR && !wdata_c[0])
      |-> ##2 !pll_reg.power_on)
    else $error("PLL not powered down.");

  pll_enable_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (commit_c && addr_reg == OFS_PWR && wdata_c[1])
      |-> ##2 pll_reg.enable)
    else $error("PLL not enabled.");

  bypass_default_a: assert property (
    @(posedge clk_i)
    rst_i |=> pll_reg.bypass && !pll_reg.enable && !pll_reg.power_on)
    else $error("PLL controls wrong after reset.");

  id_read_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (load_c && sin_reg[ADDR_W-1:0] == OFS_ID) |=> sout_reg == ID_VALUE)
    else $error("Identification read wrong.");

  id_write_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (commit_c && (addr_reg == OFS_ID || addr_reg == OFS_RSVD1))
      |=> $stable(variant_reg) && $stable(synth_reg) && $stable(pwr_reg))
    else $error("Read-only write changed state.");

  reset_hold_a: assert property (
    @(posedge clk_i)
    rst_i |=> synth_reg == SYNTH_RST && analog_reg == ANALOG_RST
      && cgen_reg == CGEN_RST && rst_reg == '1)
    else $error("Soft resets not restored.");

endmodule

// file: verilog/srpc_pkg.sv
// Constants and carrier types for the reset and PLL control register bank.
// Assumes a single 200 MHz clock and a serial configuration port host.
package srpc_pkg;

  // Serial frame layout: address, then the write flag, then the data word.
  localparam int ADDR_W     = 9;
  localparam int DATA_W     = 16;
  localparam int FRAME_BITS = ADDR_W + 1 + DATA_W;
  localparam int CNT_W      = 5;

  // Register offsets.
  localparam logic [ADDR_W-1:0] OFS_ID      = 9'h000;
  localparam logic [ADDR_W-1:0] OFS_RSVD1   = 9'h001;
  localparam logic [ADDR_W-1:0] OFS_VARIANT = 9'h002;
  localparam logic [ADDR_W-1:0] OFS_SYNTH   = 9'h008;
  localparam logic [ADDR_W-1:0] OFS_CGEN    = 9'h009;
  localparam logic [ADDR_W-1:0] OFS_ANALOG  = 9'h00a;
  localparam logic [ADDR_W-1:0] OFS_PWR     = 9'h010;

  // Code that holds a sub-block in soft reset.
  localparam logic [3:0] HOLD_CODE = 4'h9;

  // Field positions.
  localparam int SYN_PLL_LSB  = 0;
  localparam int SYN_LOCK_LSB = 4;
  localparam int CGEN_LSB     = 0;
  localparam int ANA_MUX_LSB  = 0;
  localparam int ANA_AFE_LSB  = 4;
  localparam int ANA_SER_LSB  = 8;
  localparam int PWR_ON_BIT   = 0;
  localparam int PWR_EN_BIT   = 1;
  localparam int PWR_BYP_BIT  = 2;

  // Values after reset.
  localparam logic [1:0]  VARIANT_RST = 2'h0;
  localparam logic [7:0]  SYNTH_RST   = 8'h99;
  localparam logic [3:0]  CGEN_RST    = 4'h9;
  localparam logic [11:0] ANALOG_RST  = 12'h999;
  localparam logic [2:0]  PWR_RST     = 3'h4;

  // Soft resets driven to the sub-blocks, high while held.
  typedef struct packed {
    logic pll;
    logic lock_det;
    logic clk_gen;
    logic col_mux;
    logic afe;
    logic serializer;
  } srpc_rst_t;

  // PLL controls.
  typedef struct packed {
    logic power_on;
    logic enable;
    logic bypass;
  } srpc_pll_t;

endpackage

// file: verif/tb_srpc_regs.sv
// Self-checking bench for the reset and PLL control register bank.
// Drives the serial port pins itself; no partner model stands beside it.
`timescale 1ns/10ps
module tb_srpc_regs;
  import srpc_pkg::*;
  localparam logic [15:0] ID_V = 16'h3c71;  // Arbitrary value.
  logic              clk_i = 1'b0;
  logic              rst_i = 1'b1;
  logic              ss_n_i = 1'b1;
  logic              sck_i = 1'b0;
  logic              mosi_i = 1'b0;
  logic              miso_o;
  logic              miso_oe_o;
  logic [1:0]        variant_o;
  srpc_rst_t         sub_rst_o;
  srpc_pll_t         pll_ctrl_o;
  logic [15:0]       exp_q[$];
  logic [15:0]       got_v;
  logic [15:0]       rd_v;
  logic [1:0]        var_m;
  logic [7:0]        syn_m;
  logic [3:0]        cg_m;
  logic [11:0]       an_m;
  logic [2:0]        pw_m;
  logic [31:0]       seed = 32'hb0902357;
  logic              oe_seen;
  logic [ADDR_W-1:0] al[8] = '{OFS_ID, OFS_RSVD1, OFS_VARIANT, OFS_SYNTH,
                               OFS_CGEN, OFS_ANALOG, OFS_PWR, 9'h003};
  logic [3:0]        cl[6] = '{4'h9, 4'h8, 4'ha, 4'h0, 4'hf, 4'h1};
  int                fails = 0;
  int                cmp_count = 0;
  event              res_ev;

  srpc_regs #(.ID_VALUE(ID_V)) dut (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .ss_n_i     (ss_n_i),
    .sck_i      (sck_i),
    .mosi_i     (mosi_i),
    .miso_o     (miso_o),
    .miso_oe_o  (miso_oe_o),
    .variant_o  (variant_o),
    .sub_rst_o  (sub_rst_o),
    .pll_ctrl_o (pll_ctrl_o)
  );

  initial begin
    forever #2.5 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [15:0] outs();
    return {5'h0, var_m, syn_m[3:0] == HOLD_CODE, syn_m[7:4] == HOLD_CODE,
            cg_m == HOLD_CODE, an_m[3:0] == HOLD_CODE,
            an_m[7:4] == HOLD_CODE, an_m[11:8] == HOLD_CODE,
            pw_m[0], pw_m[1], pw_m[2]};
  endfunction

  function automatic logic [15:0] rexp(input logic [ADDR_W-1:0] a);
    case (a)
      OFS_ID:      return ID_V;
      OFS_VARIANT: return {14'h0, var_m};
      OFS_SYNTH:   return {8'h0, syn_m};
      OFS_CGEN:    return {12'h0, cg_m};
      OFS_ANALOG:  return {4'h0, an_m};
      OFS_PWR:     return {13'h0, pw_m};
      default:     return 16'h0;
    endcase
  endfunction

  task automatic note(input logic [15:0] e, input logic [15:0] g);
    exp_q.push_back(e);
    got_v = g;
    ->res_ev;
    @(posedge clk_i);
  endtask

  task automatic frame(input logic [ADDR_W-1:0] a, input logic w,
                       input logic [15:0] d, input int n);
    logic [25:0] b;
    b = {a, w, d};
    @(posedge clk_i) ss_n_i <= 1'b0;
    repeat (10) @(posedge clk_i);
    for (int i = 25; i > 25 - n; i--) begin
      mosi_i <= b[i];
      repeat (10) @(posedge clk_i);
      sck_i <= 1'b1;
      rd_v = {rd_v[14:0], miso_o};
      if (i == 12) oe_seen = miso_oe_o;
      repeat (10) @(posedge clk_i);
      sck_i <= 1'b0;
    end
    repeat (10) @(posedge clk_i);
    ss_n_i <= 1'b1;
    repeat (12) @(posedge clk_i);
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
    case (a)
      OFS_VARIANT: var_m = d[1:0];
      OFS_SYNTH:   syn_m = d[7:0];
      OFS_CGEN:    cg_m = d[3:0];
      OFS_ANALOG:  an_m = d[11:0];
      OFS_PWR:     pw_m = d[2:0];
      default:     ;
    endcase
    frame(a, 1'b1, d, 26);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a);
    frame(a, 1'b0, 16'h0, 26);
    note(rexp(a), rd_v);
  endtask

  task automatic chk_out();
    note(outs(), {5'h0, variant_o, sub_rst_o, pll_ctrl_o});
  endtask

  task automatic do_reset();
    @(posedge clk_i) rst_i <= 1'b1;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    var_m = VARIANT_RST;
    syn_m = SYNTH_RST;
    cg_m = CGEN_RST;
    an_m = ANALOG_RST;
    pw_m = PWR_RST;
    @(posedge clk_i);
  endtask

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watcher: each result is compared with the oldest expectation.
  initial begin
    logic [15:0] e;
    forever begin
      @(res_ev);
      e = exp_q.pop_front();
      cmp_count++;
      if (got_v !== e) begin
        fails++;
        $display("Error at %0t: expected %h, got %h", $time, e, got_v);
      end
    end
  end

  initial begin
    repeat (90000) @(posedge clk_i);
    fails++;
    give_verdict();
  end

  initial begin
    do_reset();
    chk_out();
    for (int k = 0; k < 8; k++) rd(al[k]);
    note(16'h1, {15'h0, oe_seen});
    note(16'h0, {15'h0, miso_oe_o});
    seed = lfsr(seed);
    wr(OFS_ID, seed[15:0]);
    wr(OFS_RSVD1, seed[31:16]);
    rd(OFS_ID);
    rd(OFS_RSVD1);
    for (int v = 0; v < 4; v++) begin
      seed = lfsr(seed);
      wr(OFS_VARIANT, {seed[15:2], 2'(v)});
      chk_out();
      rd(OFS_VARIANT);
    end
    for (int k = 0; k < 6; k++) begin
      seed = lfsr(seed);
      wr(OFS_SYNTH, {seed[15:8], cl[k], cl[(k + 1) % 6]});
      wr(OFS_CGEN, {seed[19:8], cl[(k + 2) % 6]});
      wr(OFS_ANALOG, {seed[23:20], cl[k], cl[(k + 3) % 6], cl[(k + 4) % 6]});
      chk_out();
      rd(OFS_SYNTH);
      rd(OFS_CGEN);
      rd(OFS_ANALOG);
    end
    for (int p = 0; p < 8; p++) begin
      seed = lfsr(seed);
      wr(OFS_PWR, {seed[15:3], 3'(p)});
      chk_out();
      rd(OFS_PWR);
    end
    frame(OFS_SYNTH, 1'b1, 16'h0000, 20);
    chk_out();
    rd(OFS_SYNTH);
    wr(9'h0ff, 16'hffff);
    rd(9'h0ff);
    do_reset();
    chk_out();
    for (int k = 0; k < 8; k++) rd(al[k]);
    give_verdict();
  end
endmodule
